/* File: include/dmab_pkg.sv */
`default_nettype none
package dmab_pkg;

  // ==========================================================
  // Register map
  localparam logic [31:0] STATUS_ADDR = 32'hFFFFF0F0;
  localparam logic [31:0] RESTART_ADDR = 32'hFFFFF0F2;
  // Channel blocks sit at 0xFFFFF000 + 16 * channel
  localparam logic [25:0] CH_BASE_HI = 26'h3FFFFC0;
  localparam int CH_SEL_LSB = 4;
  localparam logic [3:0] OFS_SRC_HI = 4'h0;
  localparam logic [3:0] OFS_SRC_LO = 4'h2;
  localparam logic [3:0] OFS_DST_HI = 4'h4;
  localparam logic [3:0] OFS_DST_LO = 4'h6;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hA;

  // ==========================================================
  // Control register field positions
  localparam int CTL_EN = 0;
  localparam int CTL_FLY = 1;
  localparam int CTL_BLK = 2;
  localparam int CTL_RAM = 3;
  localparam int CTL_EXT = 4;

  // ==========================================================
  // Reset values and stepping
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [31:0] ADDR_STEP = 32'h00000004;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // ==========================================================
  // Bus-cycle sequencer states
  typedef enum logic [3:0] {
    idle_state,
    ready_state,
    read_setup_state,
    read_ack_wait_state,
    read_data_state,
    ram_ready_state,
    write_setup_state,
    write_ack_wait_state,
    write_data_state,
    flyby_execute_state,
    flyby_finish_state,
    flyby_decision_state,
    completion_state
  } dmab_state_t;

endpackage : dmab_pkg
`default_nettype wire

/* File: rtl/dmab_top.sv */
// Overview of operation
// - On stop input, copy the four channel enable bits into stop-status.
// - Stop-status holds until the next stop or reset; reset clears it.
// - Stop-status is read-only; flags in bits 3..0, upper bits read zero.
// - Restart bits are the channel enable bits; software sets one to restart.
// - Restart register is readable and writable as a whole.
// - Source, destination and count each have a buffer and working stage.
// - At terminal count, working registers reload from the buffer stage.
// - A preloaded transfer waits until software sets enable again.
// - In idle the four request inputs are sampled every bus clock edge.
// - Enter ready only with a request pending and the bus granted.
// - Read setup drives source address, goes to read data; ack wait too.
// - Read data repeats as waits, captures data last, then goes to RAM-ready or write.
// - RAM-ready waits for RAM bus rights, then goes to write setup.
// - Write setup drives destination; it and ack wait lead to write data.
// - Write data repeats as waits; the write strobe drops at its end.
// - Flyby execute is one state and always goes to flyby decision.
// - Decision: block with count left loops; wait to finish; else complete.
// - Flyby finish waits for the end, releases bus, goes to completion.
// - Completion ends the transfer, reinitialises only at count zero, always returns to idle.
// - Single mode releases the bus after each unit until terminal count.
// - Higher priority wins between units, except a just-late lower request.
// - Two simultaneous requests alternate; of more, the top two alternate.
// - Stop clears every enable bit and aborts any transfer in progress.
// - Terminal count output is high one clock in the final transfer cycle.
`timescale 1ns/100ps
`default_nettype none
module dmab_top
  import dmab_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [31:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic [3:0] transfer_request_in,
  input wire logic external_stop_input_in,
  input wire logic bus_grant_in,
  input wire logic ram_grant_in,
  input wire logic mem_ack_in,
  input wire logic [31:0] bus_data_in,
  input wire logic flyby_wait_in,
  input wire logic flyby_done_in,
  output logic bus_req_out,
  output logic [31:0] bus_addr_out,
  output logic bus_rd_out,
  output logic bus_wr_out,
  output logic [31:0] bus_data_out,
  output logic flyby_strobe_out,
  output logic [3:0] terminal_count_output_out
);

  // ==========================================================
  // State record
  typedef struct packed {
    dmab_state_t st;
    logic [1:0] ch;
    logic [3:0] en;
    logic [3:0] fly;
    logic [3:0] blk;
    logic [3:0] ram;
    logic [3:0] ext;
    logic [3:0] stop_cap;
    logic [3:0][31:0] src_w;
    logic [3:0][31:0] src_b;
    logic [3:0][31:0] dst_w;
    logic [3:0][31:0] dst_b;
    logic [3:0][15:0] cnt_w;
    logic [3:0][15:0] cnt_b;
    logic [2:0][3:0] req_sync;
    logic [3:0] req_f;
    logic [2:0] stop_sync;
    logic stop_f;
    logic [3:0] late;
    logic late_win;
    logic last_single;
    logic [1:0] last_ch;
    logic bus_req;
    logic rd;
    logic wr;
    logic fly_stb;
    logic [31:0] addr;
    logic [31:0] wdat;
    logic [3:0] tc;
    logic [15:0] rdata;
  } dmab_regs_t;

  dmab_regs_t r;
  dmab_regs_t n;

  logic [1:0] sel;
  logic [3:0] pend;
  logic [3:0] rise;
  logic [3:0] lower;
  logic [2:0] pick;
  logic stop_rise;
  logic last_n;
  logic ch_hit;

  // ==========================================================
  // Arbitration: fixed priority, channel 0 highest
  function automatic logic [2:0] arb_pick(
    input logic [3:0] pend_f,
    input logic [3:0] late_f,
    input logic alt,
    input logic [1:0] prev
  );
    logic [3:0] m;
    logic [1:0] t1;
    logic [1:0] t2;
    logic v2;
    m = pend_f & late_f;
    if (m == 4'h0) begin
      m = pend_f;
    end
    t1 = 2'h0;
    t2 = 2'h0;
    v2 = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        t1 = 2'(i);
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (m[i] && 2'(i) != t1) begin
        t2 = 2'(i);
        v2 = 1'b1;
      end
    end
    // A late lower request beats alternation; otherwise top two take turns
    if (alt && v2 && prev == t1 && (pend_f & late_f) == 4'h0) begin
      t1 = t2;
    end
    return {m != 4'h0, t1};
  endfunction : arb_pick

  // ==========================================================
  // Next-state logic
  always_comb begin
    n = r;
    n.tc = 4'h0;
    n.rdata = 16'h0000;
    sel = addr_in[CH_SEL_LSB +: 2];
    ch_hit = addr_in[31:6] == CH_BASE_HI;

    // Pin inputs: change taken once second and third flops agree
    n.req_sync[0] = transfer_request_in;
    n.req_sync[1] = r.req_sync[0];
    n.req_sync[2] = r.req_sync[1];
    if (r.req_sync[1] == r.req_sync[2]) begin
      n.req_f = r.req_sync[2];
    end
    n.stop_sync[0] = external_stop_input_in;
    n.stop_sync[1] = r.stop_sync[0];
    n.stop_sync[2] = r.stop_sync[1];
    if (r.stop_sync[1] == r.stop_sync[2]) begin
      n.stop_f = r.stop_sync[2];
    end
    stop_rise = n.stop_f & ~r.stop_f;
    rise = n.req_f & ~r.req_f;
    lower = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lower[i] = 2'(i) > r.ch;
    end

    // Software writes; working stage follows only while channel enable is clear
    if (wr_in && addr_in == RESTART_ADDR) begin
      n.en = wdata_in[3:0];
    end
    if (wr_in && ch_hit) begin
      case (addr_in[3:0])
        OFS_SRC_HI: begin
          n.src_b[sel][31:16] = wdata_in;
          if (!r.en[sel]) begin
            n.src_w[sel][31:16] = wdata_in;
          end
        end
        OFS_SRC_LO: begin
          n.src_b[sel][15:0] = wdata_in;
          if (!r.en[sel]) begin
            n.src_w[sel][15:0] = wdata_in;
          end
        end
        OFS_DST_HI: begin
          n.dst_b[sel][31:16] = wdata_in;
          if (!r.en[sel]) begin
            n.dst_w[sel][31:16] = wdata_in;
          end
        end
        OFS_DST_LO: begin
          n.dst_b[sel][15:0] = wdata_in;
          if (!r.en[sel]) begin
            n.dst_w[sel][15:0] = wdata_in;
          end
        end
        OFS_COUNT: begin
          n.cnt_b[sel] = wdata_in;
          if (!r.en[sel]) begin
            n.cnt_w[sel] = wdata_in;
          end
        end
        OFS_CTRL: begin
          n.en[sel] = wdata_in[CTL_EN];
          n.fly[sel] = wdata_in[CTL_FLY];
          n.blk[sel] = wdata_in[CTL_BLK];
          n.ram[sel] = wdata_in[CTL_RAM];
          n.ext[sel] = wdata_in[CTL_EXT];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid the cycle after the strobe
    if (rd_in) begin
      if (addr_in == STATUS_ADDR) begin
        n.rdata = {12'h000, r.stop_cap};
      end else if (addr_in == RESTART_ADDR) begin
        n.rdata = {12'h000, r.en};
      end else if (ch_hit) begin
        case (addr_in[3:0])
          OFS_SRC_HI: n.rdata = r.src_b[sel][31:16];
          OFS_SRC_LO: n.rdata = r.src_b[sel][15:0];
          OFS_DST_HI: n.rdata = r.dst_b[sel][31:16];
          OFS_DST_LO: n.rdata = r.dst_b[sel][15:0];
          OFS_COUNT: n.rdata = r.cnt_w[sel];
          OFS_CTRL: n.rdata = {11'h000, r.ext[sel], r.ram[sel],
                               r.blk[sel], r.fly[sel], r.en[sel]};
          default: n.rdata = 16'h0000;
        endcase
      end
    end

    // Late window: completion cycle plus the one after it
    n.late_win = r.st == completion_state;
    if (r.st == completion_state || r.late_win) begin
      n.late = r.late | (rise & lower);
    end
    pend = r.en & r.req_f;
    pick = arb_pick(pend, r.late, r.last_single, r.last_ch);

    // Bus-cycle sequencer
    case (r.st)
      idle_state: begin
        if (!r.bus_req) begin
          if (pick[2]) begin
            n.bus_req = 1'b1;
            n.ch = pick[1:0];
            n.late = 4'h0;
          end
        end else if (!r.en[r.ch]) begin
          n.bus_req = 1'b0;
        end else if (bus_grant_in) begin
          n.st = ready_state;
        end
      end
      ready_state: begin
        if (r.fly[r.ch]) begin
          n.st = flyby_execute_state;
        end else if (r.ext[r.ch]) begin
          n.st = read_ack_wait_state;
        end else begin
          n.st = read_setup_state;
        end
      end
      read_setup_state: begin
        n.st = read_data_state;
      end
      read_ack_wait_state: begin
        if (mem_ack_in) begin
          n.st = read_data_state;
        end
      end
      read_data_state: begin
        if (mem_ack_in) begin
          n.wdat = bus_data_in;
          if (r.ram[r.ch]) begin
            n.st = ram_ready_state;
          end else if (r.ext[r.ch]) begin
            n.st = write_ack_wait_state;
          end else begin
            n.st = write_setup_state;
          end
        end
      end
      ram_ready_state: begin
        if (ram_grant_in) begin
          n.st = write_setup_state;
        end
      end
      write_setup_state: begin
        n.st = write_data_state;
      end
      write_ack_wait_state: begin
        if (mem_ack_in) begin
          n.st = write_data_state;
        end
      end
      write_data_state: begin
        if (mem_ack_in) begin
          n.src_w[r.ch] = r.src_w[r.ch] + ADDR_STEP;
          n.dst_w[r.ch] = r.dst_w[r.ch] + ADDR_STEP;
          n.cnt_w[r.ch] = r.cnt_w[r.ch] - COUNT_ONE;
          // Single mode gives the bus back after every unit
          if (r.cnt_w[r.ch] == COUNT_ONE || !r.blk[r.ch]) begin
            n.bus_req = 1'b0;
            n.st = completion_state;
          end else if (r.ext[r.ch]) begin
            n.st = read_ack_wait_state;
          end else begin
            n.st = read_setup_state;
          end
        end
      end
      flyby_execute_state: begin
        n.st = flyby_decision_state;
      end
      flyby_decision_state: begin
        n.src_w[r.ch] = r.src_w[r.ch] + ADDR_STEP;
        n.cnt_w[r.ch] = r.cnt_w[r.ch] - COUNT_ONE;
        if (r.blk[r.ch] && r.cnt_w[r.ch] != COUNT_ONE) begin
          n.st = flyby_execute_state;
        end else if (flyby_wait_in) begin
          n.st = flyby_finish_state;
        end else begin
          n.bus_req = 1'b0;
          n.st = completion_state;
        end
      end
      flyby_finish_state: begin
        if (flyby_done_in) begin
          n.bus_req = 1'b0;
          n.st = completion_state;
        end
      end
      completion_state: begin
        n.st = idle_state;
        n.last_single = !r.blk[r.ch];
        n.last_ch = r.ch;
        n.late = rise & lower;
        // Count exhausted: end the channel and bring in the next setup
        if (r.cnt_w[r.ch] == COUNT_ZERO) begin
          n.en[r.ch] = 1'b0;
          n.src_w[r.ch] = r.src_b[r.ch];
          n.dst_w[r.ch] = r.dst_b[r.ch];
          n.cnt_w[r.ch] = r.cnt_b[r.ch];
        end
      end
      default: begin
        n.st = idle_state;
        n.bus_req = 1'b0;
      end
    endcase

    // Stop has the last word: capture enables, clear them, abort
    if (stop_rise) begin
      n.stop_cap = r.en;
      n.st = idle_state;
      n.bus_req = 1'b0;
    end
    if (n.stop_f) begin
      n.en = ENABLE_RESET;
    end

    // Bus strobes and address follow the state being entered
    n.rd = n.st inside {read_setup_state, read_ack_wait_state,
                        read_data_state};
    n.wr = n.st inside {write_setup_state, write_ack_wait_state,
                        write_data_state};
    n.fly_stb = n.st == flyby_execute_state;
    if (n.rd || n.fly_stb) begin
      n.addr = n.src_w[r.ch];
    end else if (n.wr) begin
      n.addr = n.dst_w[r.ch];
    end
    // One-clock terminal count as the final unit enters its write or flyby cycle
    last_n = n.cnt_w[r.ch] == COUNT_ONE;
    if (last_n && !stop_rise &&
        ((n.st inside {write_setup_state, write_ack_wait_state} &&
          r.st inside {read_data_state, ram_ready_state}) ||
         (n.st == flyby_execute_state &&
          r.st inside {ready_state, flyby_decision_state}))) begin
      n.tc[r.ch] = 1'b1;
    end
  end

  // ==========================================================
  // State register, synchronous reset to idle with bus released
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state record
  assign rdata_out = r.rdata;
  assign bus_req_out = r.bus_req;
  assign bus_addr_out = r.addr;
  assign bus_rd_out = r.rd;
  assign bus_wr_out = r.wr;
  assign bus_data_out = r.wdat;
  assign flyby_strobe_out = r.fly_stb;
  assign terminal_count_output_out = r.tc;

  // ==========================================================
  // Checks
  default clocking dmab_cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_stop_capture: assert property (
    $rose(r.stop_f) |-> r.stop_cap == $past(r.en) && r.en == 4'h0)
    else $error("stop did not capture enables");
  chk_stop_hold: assert property (
    !$rose(r.stop_f) |-> $stable(r.stop_cap))
    else $error("stop status changed without stop");
  chk_status_read: assert property (
    rd_in && addr_in == STATUS_ADDR |=>
      rdata_out == {12'h000, $past(r.stop_cap)})
    else $error("stop status read wrong");
  chk_ready_grant: assert property (
    r.st == ready_state && $past(r.st) == idle_state |->
      $past(bus_grant_in) && $past(r.bus_req))
    else $error("ready without grant");
  chk_read_setup: assert property (
    r.st == read_setup_state && !stop_rise |=>
      r.st == read_data_state && bus_rd_out)
    else $error("read setup did not reach read data");
  chk_read_capture: assert property (
    r.st == read_data_state && mem_ack_in && !stop_rise |=>
      r.st inside {ram_ready_state, write_setup_state,
                   write_ack_wait_state} &&
      bus_data_out == $past(bus_data_in))
    else $error("read data not captured");
  chk_ram_wait: assert property (
    r.st == ram_ready_state && !ram_grant_in && !stop_rise |=>
      r.st == ram_ready_state)
    else $error("ram ready left without grant");
  chk_write_setup: assert property (
    r.st == write_setup_state && !stop_rise |=>
      r.st == write_data_state && bus_wr_out)
    else $error("write setup did not reach write data");
  chk_flyby_step: assert property (
    r.st == flyby_execute_state && !stop_rise |=>
      r.st == flyby_decision_state)
    else $error("flyby execute did not reach decision");
  chk_completion_idle: assert property (
    r.st == completion_state |=> r.st == idle_state && !bus_req_out)
    else $error("completion did not return to idle");
  chk_reload_buffer: assert property (
    r.st == completion_state && r.cnt_w[r.ch] == COUNT_ZERO |=>
      r.cnt_w[$past(r.ch)] == $past(r.cnt_b[r.ch]) &&
      !r.en[$past(r.ch)])
    else $error("working count not reloaded");
  chk_tc_pulse: assert property (
    terminal_count_output_out != 4'h0 |->
      $onehot(terminal_count_output_out) ##1
      terminal_count_output_out == 4'h0)
    else $error("terminal count not a single pulse");

  cov_flyby_block: cover property (
    r.st == flyby_decision_state ##1 r.st == flyby_execute_state);
  cov_ram_write: cover property (
    r.st == ram_ready_state ##1 r.st == write_setup_state);
  cov_stop_abort: cover property (
    $rose(r.stop_f) && $past(r.st) != idle_state);

endmodule : dmab_top
`default_nettype wire

/* File: tb/dmab_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bus owner and memory controller facing the engine
module dmab_mem_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic slow_in,
  input wire logic bus_req_in,
  input wire logic bus_rd_in,
  input wire logic bus_wr_in,
  input wire logic [31:0] bus_addr_in,
  output logic bus_grant_out,
  output logic ram_grant_out,
  output logic mem_ack_out,
  output logic [31:0] bus_data_out
);
  logic [1:0] wait_q;
  // Ack after zero or two wait cycles; data lines churn when not acked
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wait_q <= 2'h0;
      mem_ack_out <= 1'b0;
      bus_grant_out <= 1'b0;
      ram_grant_out <= 1'b0;
      bus_data_out <= 32'h0;
    end else begin
      bus_grant_out <= bus_req_in;
      ram_grant_out <= bus_req_in & bus_grant_out;
      mem_ack_out <= 1'b0;
      bus_data_out <= ~bus_data_out;
      if ((bus_rd_in | bus_wr_in) && !mem_ack_out) begin
        if (wait_q == (slow_in ? 2'h2 : 2'h0)) begin
          mem_ack_out <= 1'b1;
          wait_q <= 2'h0;
          if (bus_rd_in) begin
            bus_data_out <= {16'hD000, bus_addr_in[15:0]};
          end
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end else if (!(bus_rd_in | bus_wr_in)) begin
        // An aborted access must not leave a stale wait count behind
        wait_q <= 2'h0;
      end
    end
  end
endmodule : dmab_mem_model
`default_nettype wire

/* File: tb/tb_dmab_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_dmab_top;
  import dmab_pkg::*;
  logic clk_in, reset_n_in, wr_in, rd_in, stop, slow, rd_q, req_q;
  logic fwait, fdone;
  logic grant, ram_grant, ack, bus_req, bus_rd, bus_wr, fly_stb;
  logic [31:0] addr_in, mem_data, bus_addr, bus_dout, rd_addr, wr_addr;
  logic [31:0] wr_data;
  logic [15:0] wdata_in, rdata_out, rd_val;
  logic [3:0] req, tc;
  logic [3:0] order[$];
  int bad_count, n_tests, cycles, tc_cnt, fly_cnt, req_rises;
  dmab_top u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .transfer_request_in(req),
    .external_stop_input_in(stop), .bus_grant_in(grant),
    .ram_grant_in(ram_grant), .mem_ack_in(ack), .bus_data_in(mem_data),
    .flyby_wait_in(fwait), .flyby_done_in(fdone), .bus_req_out(bus_req),
    .bus_addr_out(bus_addr), .bus_rd_out(bus_rd), .bus_wr_out(bus_wr),
    .bus_data_out(bus_dout), .flyby_strobe_out(fly_stb),
    .terminal_count_output_out(tc));
  dmab_mem_model u_mem (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .slow_in(slow), .bus_req_in(bus_req), .bus_rd_in(bus_rd),
    .bus_wr_in(bus_wr), .bus_addr_in(bus_addr), .bus_grant_out(grant),
    .ram_grant_out(ram_grant), .mem_ack_out(ack), .bus_data_out(mem_data));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ==========================================================
  // Observer of the system side, plus the hang guard
  always @(posedge clk_in) begin
    rd_q <= bus_rd;
    req_q <= bus_req;
    cycles <= cycles + 1;
    tc_cnt <= tc_cnt + $countones(tc);
    fly_cnt <= fly_cnt + int'(fly_stb);
    req_rises <= req_rises + int'(bus_req && !req_q);
    if (bus_rd && !rd_q) begin
      rd_addr <= bus_addr;
      order.push_back(bus_addr[15:12]);
    end
    if (bus_wr) begin
      wr_addr <= bus_addr;
      wr_data <= bus_dout;
    end
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wreg(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [31:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
  endtask : rreg
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  function automatic logic [31:0] cha(input int c, input logic [3:0] o);
    return 32'hFFFFF000 + 32'(c * 16) + {28'h0, o};
  endfunction : cha
  // Channel c: source c100, destination c800, count n
  task automatic setup(input int c, input logic [15:0] n);
    wreg(cha(c, OFS_SRC_HI), 16'h0000);
    wreg(cha(c, OFS_SRC_LO), {4'(c), 12'h100});
    wreg(cha(c, OFS_DST_HI), 16'h0000);
    wreg(cha(c, OFS_DST_LO), {4'(c), 12'h800});
    wreg(cha(c, OFS_COUNT), n);
  endtask : setup
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check("bus_req", {31'h0, bus_req}, 32'h0);
    check("tc", {28'h0, tc}, 32'h0);
    rreg(STATUS_ADDR);
    check("status", {16'h0, rd_val}, 32'h0);
    rreg(RESTART_ADDR);
    check("restart", {16'h0, rd_val}, 32'h0);
    wreg(STATUS_ADDR, 16'hFFFF);
    rreg(STATUS_ADDR);
    check("status_ro", {16'h0, rd_val}, 32'h0);
    rreg(32'hFFFFF0FE);
    check("unmapped", {16'h0, rd_val}, 32'h0);
    $display("reset test done");
  endtask : t_reset
  // One single-mode unit, then proof that no new start comes unasked
  task automatic t_unit(input int c, input logic [15:0] ctl, input logic sl);
    int t0, f0, r0;
    t0 = tc_cnt;
    f0 = fly_cnt;
    setup(c, COUNT_ONE);
    slow <= sl;
    wreg(cha(c, OFS_CTRL), ctl);
    req[c] <= 1'b1;
    for (int n = 0; n < 100 && tc_cnt == t0; n++) tick(1);
    for (int n = 0; n < 40 && bus_req; n++) tick(1);
    @(posedge clk_in);
    req[c] <= 1'b0;
    tick(4);
    check("tc_pulses", 32'(tc_cnt - t0), 32'h1);
    if (ctl[CTL_FLY]) begin
      check("fly_cycles", 32'(fly_cnt - f0), 32'h1);
    end else begin
      check("rd_addr", rd_addr, {16'h0, 4'(c), 12'h100});
      check("wr_addr", wr_addr, {16'h0, 4'(c), 12'h800});
      check("wr_data", wr_data, {16'hD000, 4'(c), 12'h100});
    end
    check("wr_low", {31'h0, bus_wr}, 32'h0);
    check("bus_freed", {31'h0, bus_req}, 32'h0);
    rreg(RESTART_ADDR);
    check("en_clear", {31'h0, rd_val[c]}, 32'h0);
    rreg(cha(c, OFS_COUNT));
    check("reload", {16'h0, rd_val}, 32'h1);
    r0 = req_rises;
    @(posedge clk_in);
    req[c] <= 1'b1;
    tick(12);
    check("no_restart", 32'(req_rises - r0), 32'h0);
    @(posedge clk_in);
    req[c] <= 1'b0;
    tick(4);
    $display("unit test done ch %0d", c);
  endtask : t_unit
  task automatic t_stop;
    int t0;
    t0 = tc_cnt;
    setup(0, COUNT_ONE);
    slow <= 1'b1;
    wreg(RESTART_ADDR, 16'h0004);
    wreg(cha(0, OFS_CTRL), 16'h0011);
    req[0] <= 1'b1;
    for (int n = 0; n < 40 && !bus_rd; n++) tick(1);
    @(posedge clk_in);
    stop <= 1'b1;
    tick(8);
    @(posedge clk_in);
    req[0] <= 1'b0;
    check("abort_bus", {31'h0, bus_req}, 32'h0);
    check("abort_tc", 32'(tc_cnt - t0), 32'h0);
    rreg(STATUS_ADDR);
    check("captured", {16'h0, rd_val}, 32'h5);
    rreg(RESTART_ADDR);
    check("en_dropped", {16'h0, rd_val}, 32'h0);
    @(posedge clk_in);
    stop <= 1'b0;
    tick(5);
    wreg(RESTART_ADDR, 16'h000A);
    rreg(RESTART_ADDR);
    check("restart_rw", {16'h0, rd_val}, 32'hA);
    tick(1);
    check("rdata_drop", {16'h0, rdata_out}, 32'h0);
    rreg(STATUS_ADDR);
    check("status_held", {16'h0, rd_val}, 32'h5);
    wreg(RESTART_ADDR, 16'h0000);
    stop <= 1'b1;
    tick(6);
    @(posedge clk_in);
    stop <= 1'b0;
    tick(5);
    rreg(STATUS_ADDR);
    check("recaptured", {16'h0, rd_val}, 32'h0);
    $display("stop test done");
  endtask : t_stop
  // Block flyby: two units in one bus tenure, then a waited finish
  task automatic t_block;
    int t0, f0, r0;
    t0 = tc_cnt;
    f0 = fly_cnt;
    r0 = req_rises;
    setup(1, 16'h0002);
    {fwait, fdone} <= 2'b10;
    wreg(cha(1, OFS_CTRL), 16'h0007);
    req[1] <= 1'b1;
    for (int n = 0; n < 100 && tc_cnt == t0; n++) tick(1);
    tick(4);
    check("blk_held", {31'h0, bus_req}, 32'h1);
    @(posedge clk_in);
    {fwait, fdone} <= 2'b01;
    req[1] <= 1'b0;
    tick(6);
    check("blk_units", 32'(fly_cnt - f0), 32'h2);
    check("blk_tenure", 32'(req_rises - r0), 32'h1);
    check("blk_tc", 32'(tc_cnt - t0), 32'h1);
    check("blk_freed", {31'h0, bus_req}, 32'h0);
    $display("block test done");
  endtask : t_block
  // Two requests raised together take turns unit by unit
  task automatic t_prio;
    int t0;
    setup(0, 16'h0002);
    slow <= 1'b0;
    setup(3, 16'h0002);
    wreg(cha(0, OFS_CTRL), 16'h0001);
    wreg(cha(3, OFS_CTRL), 16'h0001);
    order.delete();
    t0 = tc_cnt;
    req <= 4'h9;
    for (int n = 0; n < 300 && tc_cnt - t0 < 2; n++) tick(1);
    @(posedge clk_in);
    req <= 4'h0;
    tick(10);
    check("units", 32'(order.size()), 32'h4);
    for (int i = 0; i < 4 && i < order.size(); i++) begin
      check("turn", {28'h0, order[i]}, (i % 2 == 1) ? 32'h3 : 32'h0);
    end
    $display("priority test done");
  endtask : t_prio
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    {wr_in, rd_in, stop, slow} = 4'h0;
    {fwait, fdone} = 2'b01;
    addr_in = 32'h0;
    wdata_in = 16'h0;
    req = 4'h0;
    {bad_count, n_tests, cycles, tc_cnt, fly_cnt, req_rises} = '0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    tick(2);
    t_reset();
    t_unit(0, 16'h0001, 1'b0);
    t_unit(1, 16'h0011, 1'b1);
    t_unit(2, 16'h0009, 1'b0);
    t_unit(3, 16'h0003, 1'b0);
    t_stop();
    t_block();
    t_prio();
    finish_test();
  end
endmodule : tb_dmab_top
`default_nettype wire
